/* src/sar_adc_sequencer.sv */
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer #(
  parameter int OSC_DIV_P = sar_adc_pkg::OSC_DIV
) (
  input  wire logic                           SYS_CLK,
  input  wire logic                           RSTN,
  input  wire logic                           WB_CYC_I,
  input  wire logic                           WB_STB_I,
  input  wire logic                           WB_WE_I,
  input  wire logic [sar_adc_pkg::ADR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]                     WB_SEL_I,
  input  wire logic [31:0]                    WB_DAT_I,
  output logic      [31:0]                    WB_DAT_O,
  output logic                                WB_ACK_O,
  input  wire logic                           SUB_MAIN_CLK_EN,
  input  wire logic                           MAIN_CLK_EN,
  input  wire logic                           AUX_CLK_EN,
  input  wire logic                           TRIG_TA1,
  input  wire logic                           TRIG_TB0,
  input  wire logic                           TRIG_TB1,
  input  wire logic                           CMP_IN,
  output logic      [sar_adc_pkg::RES_W-1:0]  SAR_DAC,
  output logic                                SAMPLE_CTRL,
  output logic                                MUX_CONNECT,
  output logic      [3:0]                     MUX_CHAN,
  output logic      [2:0]                     REF_SEL,
  output logic                                CORE_PWR,
  output logic                                OSC_EN,
  output logic                                REF_ON,
  output logic                                REF_2V5,
  output logic      [7:0]                     PORT_BUF_DIS
);
  import sar_adc_pkg::*;

  if (OSC_DIV_P < 1 || OSC_DIV_P > 255) begin : g_chk
    $error("OSC_DIV_P out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic              ack_q;
  logic              enc_q;
  logic              sc_q;
  logic              ref_on_a_q;
  logic              ref25_q;
  logic [3:0]        sht_lo_q;
  logic [3:0]        sht_hi_q;
  logic [1:0]        mode_q;
  logic [1:0]        ssel_q;
  logic [2:0]        div_q;
  logic              shp_q;
  logic              trig_invert_q;
  logic [1:0]        shs_q;
  logic [3:0]        cst_q;
  logic [7:0]        port_q;
  logic [15:0]       flag_q;
  logic [15:0]       flag_d;
  logic [7:0]        mctl_q [NUM_MEM];
  logic [RES_W-1:0]  mem_q [NUM_MEM];
  state_t            state_q;
  state_t            state_d;
  logic [3:0]        ptr_q;
  logic [10:0]       cnt_q;
  logic [RES_W-1:0]  dac_q;
  logic [RES_W-1:0]  mask_q;
  logic              shi_q;
  logic              done_q;
  logic [2:0]        dcnt_q;
  logic [7:0]        ocnt_q;
  logic              osc_tick_q;
  logic              tick_q;
  logic [3:0]        chan_q;
  logic              connect_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  wire        bus_req  = WB_CYC_I & WB_STB_I & ~ack_q;
  wire        wr       = bus_req & WB_WE_I;
  wire        rd       = bus_req & ~WB_WE_I;
  wire [3:0]  idx      = WB_ADR_I[5:2];
  wire        aligned  = WB_ADR_I[1:0] == 2'h0;
  wire        hit_c0   = WB_ADR_I == ADR_CTL0;
  wire        hit_c1   = WB_ADR_I == ADR_CTL1;
  wire        hit_flag = WB_ADR_I == ADR_FLAG;
  wire        hit_port = WB_ADR_I == ADR_PORT;
  wire        hit_mctl = aligned & (WB_ADR_I[7:6] == REG_MCTL);
  wire        hit_mem  = aligned & (WB_ADR_I[7:6] == REG_MEM);
  wire        busy     = state_q != ST_IDLE;
  wire [31:0] rd_c0    = {20'h0, sht_hi_q, sht_lo_q, ref25_q, ref_on_a_q, sc_q, enc_q};
  wire [31:0] rd_c1    = {15'h0, busy, cst_q, 1'b0, shs_q, trig_invert_q, shp_q, div_q,
                          ssel_q, mode_q};
  wire [31:0] rdat     = hit_c0   ? rd_c0 :
                         hit_c1   ? rd_c1 :
                         hit_flag ? {16'h0, flag_q} :
                         hit_port ? {24'h0, port_q} :
                         hit_mctl ? {24'h0, mctl_q[idx]} :
                         hit_mem  ? {20'h0, mem_q[idx]} : 32'h0;
  wire [31:0] wdat     = merge(rdat, WB_DAT_I, WB_SEL_I);
  wire        unlocked = ~enc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock: source select then divide by 1..8
  wire src_tick = (ssel_q == SRC_OSC)  ? osc_tick_q :
                  (ssel_q == SRC_AUX)  ? AUX_CLK_EN :
                  (ssel_q == SRC_MAIN) ? MAIN_CLK_EN : SUB_MAIN_CLK_EN;
  wire div_wrap = src_tick & (dcnt_q == div_q);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger and sequencing
  wire trig_raw = (shs_q == 2'h0) ? sc_q :
                  (shs_q == 2'h1) ? TRIG_TA1 :
                  (shs_q == 2'h2) ? TRIG_TB0 : TRIG_TB1;
  wire sample_input      = trig_raw ^ trig_invert_q;
  wire shi_rise = sample_input & ~shi_q;
  wire start    = enc_q & ~done_q & shi_rise;
  wire [7:0]  cur      = mctl_q[ptr_q];
  wire        cur_eos  = cur[MC_EOS];
  wire [10:0] stime    = samp_ticks(ptr_q[3] ? sht_hi_q : sht_lo_q);
  wire        store    = (state_q == ST_CONV) & tick_q & (mask_q == 12'h0);
  wire        seq_mode = mode_q[0];
  wire        seq_next = seq_mode & ~cur_eos;
  wire        last_one = ~mode_q[1] & ~seq_next;
  wire [RES_W-1:0] dac_trial = (CMP_IN ? dac_q : (dac_q & ~mask_q)) | (mask_q >> 1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = shp_q ? ST_SYNC : ST_SAMP;
        end
      end
      ST_SYNC: begin
        if (tick_q) begin
          state_d = ST_SAMP;
        end
      end
      ST_SAMP: begin
        if (tick_q && (shp_q ? (cnt_q == 11'h0) : ~sample_input)) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (store) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    flag_d = flag_q;
    if (wr && hit_flag) begin
      flag_d = flag_d & ~wdat[15:0];
    end
    if (rd && hit_mem) begin
      flag_d[idx] = 1'b0;
    end
    if (store) begin
      flag_d[ptr_q] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q    <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      ack_q    <= bus_req;
      WB_DAT_O <= rd ? rdat : 32'h0;
    end
  end
  assign WB_ACK_O = ack_q;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      enc_q    <= 1'b0;
      ref_on_a_q  <= 1'b0;
      ref25_q  <= 1'b0;
      sht_lo_q <= 4'h0;
      sht_hi_q <= 4'h0;
    end else if (wr && hit_c0) begin
      enc_q    <= wdat[C0_ENC];
      ref_on_a_q  <= wdat[C0_REF];
      ref25_q  <= wdat[C0_25V];
      if (unlocked) begin
        sht_lo_q <= wdat[C0_SLO +: 4];
        sht_hi_q <= wdat[C0_SHI +: 4];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sc_q <= 1'b0;
    end else if (wr && hit_c0) begin
      sc_q <= wdat[C0_SC];
    end else if (store) begin
      sc_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      {mode_q, ssel_q, div_q, shp_q, trig_invert_q, shs_q, cst_q} <= '0;
    end else if (wr && hit_c1 && unlocked) begin
      mode_q <= wdat[C1_MODE +: 2];
      ssel_q <= wdat[C1_SSEL +: 2];
      div_q  <= wdat[C1_DIV +: 3];
      shp_q  <= wdat[C1_SHP];
      trig_invert_q <= wdat[C1_TRIG_INVERT];
      shs_q  <= wdat[C1_SHS +: 2];
      cst_q  <= wdat[C1_CST +: 4];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      port_q <= 8'h0;
    end else if (wr && hit_port) begin
      port_q <= wdat[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_MEM; i++) begin
        mctl_q[i] <= 8'h0;
        mem_q[i]  <= '0;
      end
    end else begin
      if (wr && hit_mctl && unlocked) begin
        mctl_q[idx] <= wdat[7:0];
      end
      if (store) begin
        mem_q[ptr_q] <= dac_q;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      flag_q <= 16'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Internal oscillator runs only while enabled
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ocnt_q     <= 8'h0;
      osc_tick_q <= 1'b0;
    end else begin
      osc_tick_q <= OSC_EN & (ocnt_q == 8'(OSC_DIV_P - 1));
      if (!OSC_EN || ocnt_q == 8'(OSC_DIV_P - 1)) begin
        ocnt_q <= 8'h0;
      end else begin
        ocnt_q <= ocnt_q + 8'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dcnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_wrap;
      if (div_wrap) begin
        dcnt_q <= 3'h0;
      end else if (src_tick) begin
        dcnt_q <= dcnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      shi_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      shi_q   <= sample_input;
      if (!enc_q || (wr && hit_c0 && wdat[C0_SC])) begin
        done_q <= 1'b0;
      end else if (store && last_one && shs_q != 2'h0) begin
        done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ptr_q <= 4'h0;
    end else if (!enc_q || (state_q == ST_IDLE && !seq_mode)) begin
      ptr_q <= cst_q;
    end else if (store) begin
      ptr_q <= seq_next ? ptr_q + 4'h1 : cst_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q  <= 11'h0;
      dac_q  <= '0;
      mask_q <= '0;
    end else if (state_q == ST_SYNC && tick_q) begin
      cnt_q <= stime - 11'h1;
    end else if (state_q == ST_SAMP && tick_q) begin
      cnt_q <= cnt_q - 11'h1;
      dac_q  <= DAC_MID;
      mask_q <= DAC_MID;
    end else if (state_q == ST_CONV && tick_q && mask_q != 12'h0) begin
      dac_q  <= dac_trial;
      mask_q <= mask_q >> 1;
    end
  end

  // Break before make: channel only changes while disconnected
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      chan_q    <= 4'h0;
      connect_q <= 1'b0;
      REF_SEL   <= 3'h0;
    end else begin
      connect_q <= (state_d == ST_SAMP) & (chan_q == cur[3:0]);
      if (!connect_q) begin
        chan_q  <= cur[3:0];
        REF_SEL <= cur[MC_REF +: 3];
      end
    end
  end
  assign MUX_CONNECT = connect_q;
  assign MUX_CHAN    = chan_q;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SAMPLE_CTRL  <= 1'b0;
      CORE_PWR     <= 1'b0;
      OSC_EN       <= 1'b0;
      REF_ON       <= 1'b0;
      REF_2V5      <= 1'b0;
      PORT_BUF_DIS <= 8'h0;
    end else begin
      SAMPLE_CTRL  <= state_d == ST_SAMP;
      CORE_PWR     <= state_d != ST_IDLE;
      OSC_EN       <= (state_d != ST_IDLE) & (ssel_q == SRC_OSC);
      REF_ON       <= ref_on_a_q;
      REF_2V5      <= ref25_q;
      PORT_BUF_DIS <= port_q;
    end
  end
  assign SAR_DAC = dac_q;

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] ctk_q;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctk_q <= 5'h0;
    end else if (state_q != ST_CONV) begin
      ctk_q <= 5'h0;
    end else if (tick_q) begin
      ctk_q <= ctk_q + 5'h1;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_conv_len: assert property (store |-> ctk_q == 5'd12)
    else $error("conversion not 13 clocks");
  a_needs_enc: assert property (state_q == ST_IDLE && !enc_q |=> state_q == ST_IDLE)
    else $error("conversion without enable");
  a_start_edge: assert property (state_q == ST_IDLE && state_d != ST_IDLE |-> sample_input && !shi_q)
    else $error("start without rising edge");
  a_flag_set: assert property (store |=> flag_q[$past(ptr_q)])
    else $error("result flag not set");
  a_mux_open: assert property (MUX_CONNECT |-> SAMPLE_CTRL)
    else $error("input connected outside sampling");
  a_break_make: assert property (chan_q != $past(chan_q) |-> !$past(MUX_CONNECT) && !MUX_CONNECT)
    else $error("channel switched while connected");
  a_seq_wrap: assert property (store && seq_next && ptr_q == 4'hF |=> ptr_q == 4'h0)
    else $error("pointer did not wrap");
  a_eos_back: assert property (store && cur_eos |=> ptr_q == $past(cst_q))
    else $error("sequence not ended at end bit");
  a_osc_pwr: assert property (!CORE_PWR |-> !OSC_EN)
    else $error("oscillator on while core idle");
  a_lock_ctl: assert property (enc_q && wr && hit_c1 |=> $stable(mode_q))
    else $error("mode changed while enabled");

  c_single: cover property (store && mode_q == 2'h0);
  c_wrap: cover property (store && seq_next && ptr_q == 4'hF);
  c_pulse: cover property (shp_q && state_q == ST_SAMP ##[1:200] store);
endmodule : sar_adc_sequencer
`default_nettype wire

/* src/sar_adc_pkg.sv */
package sar_adc_pkg;
  localparam int ADR_W      = 8;
  localparam int NUM_MEM    = 16;
  localparam int RES_W      = 12;
  localparam int CONV_CLKS  = 13;
  localparam int SYS_CLK_MHZ = 100;
  localparam int OSC_PERIOD_NS = 200;
  localparam int OSC_DIV    = OSC_PERIOD_NS * SYS_CLK_MHZ / 1000;
  localparam logic [7:0] ADR_CTL0 = 8'h00;
  localparam logic [7:0] ADR_CTL1 = 8'h04;
  localparam logic [7:0] ADR_FLAG = 8'h08;
  localparam logic [7:0] ADR_PORT = 8'h0C;
  localparam logic [1:0] REG_MCTL = 2'h1;
  localparam logic [1:0] REG_MEM  = 2'h2;
  localparam int C0_ENC = 0;
  localparam int C0_SC  = 1;
  localparam int C0_REF = 2;
  localparam int C0_25V = 3;
  localparam int C0_SLO = 4;
  localparam int C0_SHI = 8;
  localparam int C1_MODE = 0;
  localparam int C1_SSEL = 2;
  localparam int C1_DIV  = 4;
  localparam int C1_SHP  = 7;
  localparam int C1_TRIG_INVERT = 8;
  localparam int C1_SHS  = 9;
  localparam int C1_CST  = 12;
  localparam int C1_BUSY = 16;
  localparam int MC_EOS  = 7;
  localparam int MC_REF  = 4;
  localparam logic [1:0] SRC_OSC = 2'h0;
  localparam logic [1:0] SRC_AUX = 2'h1;
  localparam logic [1:0] SRC_MAIN = 2'h2;
  localparam logic [1:0] SRC_SUB = 2'h3;
  localparam logic [RES_W-1:0] DAC_MID = 12'h800;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SAMP, ST_CONV} state_t;

  function automatic logic [10:0] samp_ticks(input logic [3:0] code);
    case (code)
      4'h0:    samp_ticks = 11'h004;
      4'h1:    samp_ticks = 11'h008;
      4'h2:    samp_ticks = 11'h010;
      4'h3:    samp_ticks = 11'h020;
      4'h4:    samp_ticks = 11'h040;
      4'h5:    samp_ticks = 11'h060;
      4'h6:    samp_ticks = 11'h080;
      4'h7:    samp_ticks = 11'h0C0;
      4'h8:    samp_ticks = 11'h100;
      4'h9:    samp_ticks = 11'h180;
      4'hA:    samp_ticks = 11'h200;
      4'hB:    samp_ticks = 11'h300;
      default: samp_ticks = 11'h400;
    endcase
  endfunction : samp_ticks

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge
endpackage : sar_adc_pkg

/* testbench/sar_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
module sar_far_side (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [191:0] levels,
  input  wire logic [3:0]   chan,
  input  wire logic         connect,
  input  wire logic [11:0]  dac,
  output logic              cmp,
  output logic              main_en,
  output logic              aux_en,
  output logic              sub_en
);
  logic [11:0] held_q;
  logic [1:0]  div_q;

  // Source clocks run freely, so no conversion ever loses its clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 12'h000;
      div_q  <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
      if (connect) begin
        held_q <= levels[12*chan +: 12];
      end
    end
  end

  // Held level only follows the input while connected
  assign cmp     = (held_q >= dac);
  assign main_en = 1'b1;
  assign aux_en  = (div_q == 2'h3);
  assign sub_en  = div_q[0];
endmodule : sar_far_side
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sar_adc_pkg::*;
  logic         clk, rst_n, cyc, stb, we, ack, cmp, samp, conn, core, osc, ref_on, ref_hi;
  logic         main_en, aux_en, sub_en, was_s, was_c, inv;
  logic [2:0]   trig, rsel;
  logic [3:0]   chan, last_ch, e;
  logic [7:0]   adr, pbd;
  logic [11:0]  dac;
  logic [31:0]  wdat, rdat, rd, lfsr;
  logic [191:0] levels;
  logic [3:0]   ent_ch [16];
  int           n_fail, check_count, cycles, run, cnt_c;

  sar_adc_sequencer #(.OSC_DIV_P(2)) uut (
    .SYS_CLK(clk), .RSTN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SUB_MAIN_CLK_EN(sub_en), .MAIN_CLK_EN(main_en), .AUX_CLK_EN(aux_en),
    .TRIG_TA1(trig[0]), .TRIG_TB0(trig[1]), .TRIG_TB1(trig[2]), .CMP_IN(cmp),
    .SAR_DAC(dac), .SAMPLE_CTRL(samp), .MUX_CONNECT(conn), .MUX_CHAN(chan), .REF_SEL(rsel),
    .CORE_PWR(core), .OSC_EN(osc), .REF_ON(ref_on), .REF_2V5(ref_hi), .PORT_BUF_DIS(pbd));

  sar_far_side far (
    .clk(clk), .rst_n(rst_n), .levels(levels), .chan(chan), .connect(conn), .dac(dac),
    .cmp(cmp), .main_en(main_en), .aux_en(aux_en), .sub_en(sub_en));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic int ticks(input logic [3:0] c);
    ticks = 4 << c;
  endfunction : ticks

  function automatic logic [31:0] c0(input logic sc, input logic [3:0] lo, input logic [3:0] hi);
    c0 = {20'h00000, hi, lo, 2'h0, sc, 1'b1};
  endfunction : c0

  function automatic logic [31:0] c1(input logic [3:0] st, input logic [1:0] s, input logic v,
                                     input logic p, input logic [2:0] d, input logic [1:0] src,
                                     input logic [1:0] m);
    c1 = {16'h0000, st, 1'b0, s, v, p, d, src, m};
  endfunction : c1

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk_rng

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic ent(input logic [3:0] i, input logic [3:0] ch, input logic seq_end);
    ent_ch[i] = ch;
    wb(1'b1, 8'h40 + {2'h0, i, 2'h0}, {24'h0, seq_end, ch[2:0], ch});
  endtask : ent

  // Software start: enable first, then raise the start bit
  task automatic go(input logic [3:0] lo, input logic [3:0] hi);
    wb(1'b1, ADR_CTL0, c0(1'b0, lo, hi));
    wb(1'b1, ADR_CTL0, c0(1'b1, lo, hi));
  endtask : go

  task automatic get(input logic [3:0] i);
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[i] !== 1'b1 && k < 2000) begin
      wb(1'b0, ADR_FLAG, 32'h0);
      k++;
    end
    chk({31'h0, rd[i]}, 32'h1);
    wb(1'b0, 8'h80 + {2'h0, i, 2'h0}, 32'h0);
    chk(rd, {20'h0, levels[12*ent_ch[i] +: 12]});
    chk({30'h0, core, osc}, 32'h0);
  endtask : get

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    was_s <= samp;
    was_c <= conn;
    last_ch <= chan;
    if (samp === 1'b1) run <= (was_s === 1'b1) ? run + 1 : 1;
    if (samp === 1'b1) cnt_c <= 0;
    else if (core === 1'b1) cnt_c <= cnt_c + 1;
    if (conn === 1'b1) chk({31'h0, samp}, 32'h1);
    if (conn === 1'b1 && was_c === 1'b1) chk({28'h0, chan}, {28'h0, last_ch});
    if (cycles == 80000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    {rst_n, cyc, stb, we, trig, adr, wdat} = '0;
    {n_fail, check_count, cycles, run, cnt_c} = '0;
    lfsr = 32'h000154BB;
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      levels[12*i +: 12] = lfsr[11:0];
    end
    levels[23:0] = 24'h000FFF;
    repeat (8) @(posedge clk);
    chk({18'h0, pbd, samp, conn, core, osc, ref_on, ref_hi}, 32'h0);
    rst_n <= 1'b1;
    // Reference settling wait is left to software; no conversion here uses it
    // Reference, port buffers and an unmapped address
    wb(1'b1, ADR_CTL0, 32'h0000000C);
    repeat (2) @(posedge clk);
    chk({30'h0, ref_on, ref_hi}, 32'h3);
    wb(1'b1, ADR_CTL0, 32'h00000004);
    repeat (2) @(posedge clk);
    chk({30'h0, ref_on, ref_hi}, 32'h2);
    wb(1'b1, ADR_PORT, {24'h0, lfsr[23:16]});
    repeat (2) @(posedge clk);
    chk({24'h0, pbd}, {24'h0, lfsr[23:16]});
    wb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    // Start bit without enable must do nothing
    wb(1'b1, ADR_CTL0, 32'h0);
    wb(1'b1, ADR_CTL1, c1(4'h0, 2'h0, 1'b0, 1'b1, 3'h0, SRC_MAIN, 2'h0));
    wb(1'b1, ADR_CTL0, 32'h00000002);
    repeat (200) @(posedge clk);
    wb(1'b0, ADR_FLAG, 32'h0);
    chk(rd, 32'h0);
    // Single conversions over every clock source and random dividers
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      e = lfsr[15:12];
      wb(1'b1, ADR_CTL0, 32'h0);
      wb(1'b1, ADR_CTL1, c1(e, 2'h0, 1'b0, 1'b1, lfsr[6:4], 2'(i), 2'h0));
      ent(e, (i < 2) ? 4'(i) : 4'(lfsr[27:24] % 12), 1'b0);
      go(lfsr[9:8], 4'h0);
      get(e);
    end
    // Pulse length from the low and high sample time fields
    for (int j = 0; j < 2; j++) begin
      e = j ? 4'h9 : 4'h3;
      wb(1'b1, ADR_CTL0, 32'h0);
      wb(1'b1, ADR_CTL1, c1(e, 2'h0, 1'b0, 1'b1, 3'h0, SRC_MAIN, 2'h0));
      ent(e, 4'h5, 1'b0);
      go(4'h3, 4'h1);
      get(e);
      chk_rng(run, ticks(j ? 4'h1 : 4'h3), ticks(j ? 4'h1 : 4'h3) + 1);
      chk_rng(cnt_c, CONV_CLKS, CONV_CLKS + 1);
    end
    // Sequence, repeat single and repeat sequence, wrapping past entry 15
    for (int m = 1; m < 4; m++) begin
      wb(1'b1, ADR_CTL0, 32'h0);
      wb(1'b1, ADR_CTL1, c1(4'hE, 2'h0, 1'b0, 1'b1, 3'h1, SRC_SUB, 2'(m)));
      ent(4'hE, 4'h2, 1'b0);
      ent(4'hF, 4'h3, 1'b0);
      ent(4'h0, 4'h4, 1'b1);
      go(4'h0, 4'h0);
      for (int k = 0; k < m + 1 + (m == 1); k++) begin
        if (k > 0) wb(1'b1, ADR_CTL0, c0(1'b1, 4'h0, 4'h0));
        get((m == 2 || k == 3) ? 4'hE : 4'(14 + k));
      end
    end
    // Extended sampling from each timer trigger, random polarity
    for (int s = 1; s < 4; s++) begin
      lfsr = nxt(lfsr);
      inv = lfsr[0];
      trig <= {3{inv}};
      wb(1'b1, ADR_CTL0, 32'h0);
      wb(1'b1, ADR_CTL1, c1(4'h5, 2'(s), inv, 1'b0, 3'h0, SRC_MAIN, 2'h0));
      ent(4'h5, 4'(s + 6), 1'b0);
      wb(1'b1, ADR_CTL0, c0(1'b0, 4'h0, 4'h0));
      @(posedge clk);
      trig[s-1] <= ~inv;
      repeat (20) @(posedge clk);
      chk({31'h0, samp}, 32'h1);
      chk({28'h0, chan}, {28'h0, 4'(s + 6)});
      chk({29'h0, rsel}, {29'h0, 3'(s + 6)});
      trig[s-1] <= inv;
      get(4'h5);
      chk_rng(run, 17, 23);
    end
    // Mode write while enabled must be ignored
    wb(1'b1, ADR_CTL1, c1(4'h0, 2'h0, 1'b0, 1'b1, 3'h0, SRC_MAIN, 2'h3));
    wb(1'b0, ADR_CTL1, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h0);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
